// ===== rtl/ptc_config_header.sv
// Type 0 configuration header register bank of a single-function target
//
// Functional notes
// (R1) Header type bit 7 reads 0: single function.
// (R2) Header type bits 6:0 read 00h: general target layout.
// (R3) Base register bit 0 is read-only and tells memory or I/O space.
// (R4) Memory base bits 31:4 are read/write and feed the decoder.
// (R5) Memory base bits 2:1 read-only type, 00b means 32-bit.
// (R6) I/O base bits 31:2 writable, bit 1 reserved read-only.
// (R7) Bits inside the region size read zero; upper bits writable for sizing.
// (R8) Unused base registers read all ones.
// (R9) Control register base: bits 5:0 read-only, bits 31:6 read/write.
// (R10) Load byte 00h picks base 0 or 5, byte 01h picks I/O or memory.
// (R11) Capability pointer gives first entry; next pointer one byte above.
// (R12) Interrupt line is software read/write, never loaded at boot.
// (R13) Interrupt pin reads 1h, first interrupt pin.
// (R14) Minimum grant and maximum latency read 00h, read-only.
// (R15) Cache line size and latency timer read zero, read-only.
// (R16) Self-test register reads zero: self-test unsupported.
// (R17) Revision is read-only, loaded at boot.
// (R18) Class code is read-only, loaded at boot, three bytes.
// (R19) Subsystem vendor and subsystem codes read-only, loaded at boot.
// (R20) Power management block sits at 40h to 47h; pointer holds 40h.
// (R21) Power management capability identifier reads fixed 01h.
// (R22) Header fields load from serial ROM before any access is answered.
// (R23) Only type 0 accesses answered; byte, word, dword all accepted.
// (R24) Writes to read-only fields are acknowledged but change nothing.
`timescale 1ns/1ns
`include "ptc_defines.svh"

module ptc_config_header #(
    parameter logic [15:0] VENDOR_CODE = 16'h0f0f,  // Arbitrary value
    parameter logic [15:0] DEVICE_CODE = 16'h0a0a   // Arbitrary value
) (
    input  wire logic              clk,
    input  wire logic              rst_b,
    input  wire ptc_pkg::ptc_req_t cfg_req,
    input  wire ptc_pkg::ptc_rom_t rom_wr,
    input  wire logic              rom_done,
    output ptc_pkg::ptc_rsp_t      cfg_rsp,
    output logic                   cfg_ready,
    output logic [25:0]            ctrl_base,
    output logic                   ctrl_is_mem,
    output logic                   ctrl_in_bar5,
    output logic [7:0]             irq_line
);
    import ptc_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // State

    ptc_state_t  state_reg;
    ptc_state_t  state_next;
    ptc_rsp_t    rsp_reg;
    logic        ready_reg;
    logic [5:0]  idx_reg;
    logic [25:0] base_reg;
    logic        mem_reg;
    logic        bar5_reg;
    logic [7:0]  irq_line_reg;
    logic [7:0]  rev_reg;
    logic [23:0] class_reg;
    logic [15:0] svid_reg;
    logic [15:0] sid_reg;
    logic [7:0]  cap_ptr_reg;
    logic [7:0]  next0_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Decode

    wire         loading   = (state_reg == PTC_LOADING);
    wire         rom_take  = rom_wr.valid && loading;
    // Requester holds its request until the ack; the ack term stops a retake
    wire         take      = cfg_req.valid && cfg_req.type0 && ready_reg
                             && !rsp_reg.ack;  // [R22] [R23]
    wire         wr_take   = take && cfg_req.write;
    wire [5:0]   ctrl_idx  = bar5_reg ? `PTC_IDX_BAR5 : `PTC_IDX_BAR0;  // [R10]
    wire         hit_ctrl  = (cfg_req.idx == ctrl_idx);
    wire         is_bar    = (cfg_req.idx >= `PTC_IDX_BAR0)
                             && (cfg_req.idx <= `PTC_IDX_BAR5);
    // Region is 64 bytes to hold 28; bits 5:0 never store anything
    wire [5:0]   ctrl_low  = {3'b000, `PTC_MEM_TYPE_32, !mem_reg};  // [R3] [R5] [R6] [R9]
    wire [31:0]  ctrl_word = {base_reg, ctrl_low};  // [R7]
    wire [31:0]  bar_word  = hit_ctrl ? ctrl_word : `PTC_BAR_UNUSED;  // [R8]

    // Byte-lane merge, so byte and word writes land correctly
    wire [31:0]  merged;
    genvar k;
    generate
        for (k = 0; k < 4; k = k + 1) begin : g_lane
            assign merged[8*k+7:8*k] = cfg_req.be[k] ? cfg_req.wdata[8*k+7:8*k]
                                                     : ctrl_word[8*k+7:8*k];
        end
    endgenerate

    wire         base_we   = wr_take && hit_ctrl;  // [R4] [R6] [R9]
    wire         line_we   = wr_take && (cfg_req.idx == `PTC_IDX_INTR)
                             && cfg_req.be[0];  // [R12]

    ////////////////////////////////////////////////////////////////////////////
    // Read mux

    logic [31:0] rd_word;
    always_comb begin
        rd_word = 32'h0000_0000;
        unique case (1'b1)
            cfg_req.idx == `PTC_IDX_ID:
                rd_word = {DEVICE_CODE, VENDOR_CODE};
            cfg_req.idx == `PTC_IDX_CLASS:
                rd_word = {class_reg, rev_reg};  // [R17] [R18]
            cfg_req.idx == `PTC_IDX_HDR:
                rd_word = {`PTC_SELF_TEST_CONTROL_VAL, `PTC_HDR_TYPE,
                           `PTC_LAT_TIMER, `PTC_CACHE_LINE};  // [R1] [R2] [R15] [R16]
            is_bar:
                rd_word = bar_word;
            cfg_req.idx == `PTC_IDX_SUBSYS:
                rd_word = {sid_reg, svid_reg};  // [R19]
            cfg_req.idx == `PTC_IDX_CAPPTR:
                rd_word = {24'h000000, cap_ptr_reg};  // [R11]
            cfg_req.idx == `PTC_IDX_INTR:
                rd_word = {`PTC_MAX_LAT, `PTC_MIN_GNT,
                           `PTC_IRQ_PIN, irq_line_reg};  // [R13] [R14]
            cfg_req.idx == `PTC_IDX_PM0:
                rd_word = {16'h0000, next0_reg, `PTC_PM_CAP_ID};  // [R20] [R21]
            default:
                rd_word = 32'h0000_0000;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Boot load sequencing

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            PTC_LOADING: if (rom_done) begin
                state_next = PTC_READY;  // [R22]
            end
            PTC_READY:   state_next = PTC_READY;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state_reg <= PTC_LOADING;
            ready_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            ready_reg <= (state_next == PTC_READY);
        end
    end

    // Loaded bytes are ignored once answering has started, so they stay read-only
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            bar5_reg    <= 1'b0;
            mem_reg     <= 1'b0;
            rev_reg     <= 8'h00;
            class_reg   <= 24'h000000;
            svid_reg    <= 16'h0000;
            sid_reg     <= 16'h0000;
            cap_ptr_reg <= `PTC_PM_CAP_OFS;
            next0_reg   <= `PTC_ZERO_BYTE;
        end else if (rom_take) begin
            unique case (rom_wr.addr)
                `PTC_ROM_BAR_SEL:   bar5_reg <= rom_wr.data[0];  // [R10]
                `PTC_ROM_SPACE:     mem_reg <= rom_wr.data[0];  // [R10]
                `PTC_ROM_REV:       rev_reg <= rom_wr.data;  // [R17]
                `PTC_ROM_CLASS_LO:  class_reg[7:0] <= rom_wr.data;  // [R18]
                `PTC_ROM_CLASS_MID: class_reg[15:8] <= rom_wr.data;  // [R18]
                `PTC_ROM_CLASS_HI:  class_reg[23:16] <= rom_wr.data;  // [R18]
                `PTC_ROM_SVID_LO:   svid_reg[7:0] <= rom_wr.data;  // [R19]
                `PTC_ROM_SVID_HI:   svid_reg[15:8] <= rom_wr.data;  // [R19]
                `PTC_ROM_SID_LO:    sid_reg[7:0] <= rom_wr.data;  // [R19]
                `PTC_ROM_SID_HI:    sid_reg[15:8] <= rom_wr.data;  // [R19]
                `PTC_ROM_CAPPTR:    cap_ptr_reg <= rom_wr.data;  // [R11]
                `PTC_ROM_NEXT0:     next0_reg <= rom_wr.data;  // [R11]
                default:            ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Configuration writes and answers

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            base_reg     <= `PTC_CTRL_BASE_RST;
            irq_line_reg <= `PTC_IRQ_LINE_RST;
        end else begin
            if (base_we) begin
                base_reg <= merged[31:6];  // [R4] [R7] [R24]
            end
            if (line_we) begin
                irq_line_reg <= cfg_req.wdata[7:0];  // [R12]
            end
        end
    end

    // Every taken access is answered; writes elsewhere are simply dropped
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rsp_reg <= '0;
            idx_reg <= 6'h00;
        end else begin
            rsp_reg.ack <= take;  // [R23] [R24]
            if (take) begin
                rsp_reg.rdata <= rd_word;
                idx_reg       <= cfg_req.idx;
            end
        end
    end

    assign cfg_rsp      = rsp_reg;
    assign cfg_ready    = ready_reg;
    assign ctrl_base    = base_reg;
    assign ctrl_is_mem  = mem_reg;
    assign ctrl_in_bar5 = bar5_reg;
    assign irq_line     = irq_line_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    wire rd_ack = rsp_reg.ack;
    wire [5:0] ack_ctrl_idx = bar5_reg ? `PTC_IDX_BAR5 : `PTC_IDX_BAR0;
    wire ack_bar = (idx_reg >= `PTC_IDX_BAR0) && (idx_reg <= `PTC_IDX_BAR5);

    chk_hdr_type_zero: assert property ( // [R1] [R2]
        rd_ack && idx_reg == `PTC_IDX_HDR |-> rsp_reg.rdata[23:16] == 8'h00)
        else $error("header type not zero");
    chk_hdr_side_bytes: assert property ( // [R15] [R16]
        rd_ack && idx_reg == `PTC_IDX_HDR
        |-> rsp_reg.rdata[31:24] == 8'h00 && rsp_reg.rdata[15:0] == 16'h0000)
        else $error("cache, latency or self-test not zero");
    chk_space_bit: assert property ( // [R3] [R10]
        rd_ack && idx_reg == ack_ctrl_idx |-> rsp_reg.rdata[0] == !mem_reg)
        else $error("space indicator wrong");
    chk_low_bits_zero: assert property ( // [R5] [R6] [R7] [R9]
        rd_ack && idx_reg == ack_ctrl_idx |-> rsp_reg.rdata[5:1] == 5'h00)
        else $error("control base low bits not zero");
    chk_unused_bar: assert property ( // [R8]
        rd_ack && ack_bar && idx_reg != ack_ctrl_idx
        |-> rsp_reg.rdata == 32'hffffffff)
        else $error("unused base not all ones");
    chk_base_write: assert property ( // [R4]
        wr_take && hit_ctrl && cfg_req.be == 4'hf
        |=> base_reg == $past(cfg_req.wdata[31:6]))
        else $error("base write lost");
    chk_base_readback: assert property ( // [R7]
        wr_take && hit_ctrl && cfg_req.be == 4'hf ##3 take && hit_ctrl && !cfg_req.write
        |=> rsp_reg.rdata[31:6] == $past(cfg_req.wdata[31:6], 4))
        else $error("base readback differs");
    chk_irq_fixed: assert property ( // [R13] [R14]
        rd_ack && idx_reg == `PTC_IDX_INTR |-> rsp_reg.rdata[31:8] == 24'h000001)
        else $error("interrupt pin or grant bytes wrong");
    chk_irq_line_write: assert property ( // [R12]
        line_we |=> irq_line_reg == $past(cfg_req.wdata[7:0]))
        else $error("interrupt line write lost");
    chk_pm_cap_id: assert property ( // [R20] [R21]
        rd_ack && idx_reg == `PTC_IDX_PM0 |-> rsp_reg.rdata[7:0] == 8'h01)
        else $error("capability identifier wrong");
    chk_cap_ptr: assert property ( // [R11]
        rd_ack && idx_reg == `PTC_IDX_CAPPTR |-> rsp_reg.rdata[7:0] == cap_ptr_reg)
        else $error("capability pointer wrong");
    chk_no_early_ack: assert property ( // [R22]
        !ready_reg |=> !rsp_reg.ack)
        else $error("answer before boot load");
    chk_type1_ignored: assert property ( // [R23]
        cfg_req.valid && !cfg_req.type0 |=> !rsp_reg.ack)
        else $error("non type 0 access answered");
    chk_ack_follows: assert property ( // [R23]
        take |=> rsp_reg.ack ##1 !rsp_reg.ack)
        else $error("answer not one cycle after take");
    chk_ro_stable: assert property ( // [R24] [R17] [R18] [R19]
        ready_reg |=> $stable(rev_reg) && $stable(class_reg)
                      && $stable(svid_reg) && $stable(sid_reg))
        else $error("read-only field changed");
    chk_rom_rev: assert property ( // [R17]
        rom_take && rom_wr.addr == `PTC_ROM_REV |=> rev_reg == $past(rom_wr.data))
        else $error("revision not loaded");

    ////////////////////////////////////////////////////////////////////////////
    // Write, load and readback checks
    // Reads are checked from the take edge, since a write answer carries the old word

    chk_base_hold: assert property ( // [R9] [R24]
        !base_we |=> $stable(base_reg))
        else $error("control base changed without a write");
    chk_line_hold: assert property ( // [R12]
        !line_we |=> $stable(irq_line_reg))
        else $error("interrupt line changed without a write");
    chk_ro_write_drop: assert property ( // [R24]
        wr_take && !hit_ctrl && cfg_req.idx != `PTC_IDX_INTR
        |=> $stable(base_reg) && $stable(irq_line_reg))
        else $error("write to read-only field took effect");
    chk_ready_on_done: assert property ( // [R22]
        loading && rom_done |=> ready_reg)
        else $error("ready missing after boot load");
    chk_ready_waits: assert property ( // [R22]
        loading && !rom_done |=> !ready_reg)
        else $error("ready before boot load finished");
    chk_sel_stable: assert property ( // [R10]
        ready_reg |=> $stable(bar5_reg) && $stable(mem_reg))
        else $error("region selection changed after boot");
    chk_rom_select: assert property ( // [R10]
        rom_take && rom_wr.addr == `PTC_ROM_BAR_SEL
        |=> bar5_reg == $past(rom_wr.data[0]))
        else $error("base select not loaded");
    chk_rom_space: assert property ( // [R10]
        rom_take && rom_wr.addr == `PTC_ROM_SPACE
        |=> mem_reg == $past(rom_wr.data[0]))
        else $error("space select not loaded");
    chk_rom_class: assert property ( // [R18]
        rom_take && rom_wr.addr == `PTC_ROM_CLASS_HI
        |=> class_reg[23:16] == $past(rom_wr.data))
        else $error("class code not loaded");
    chk_rom_board: assert property ( // [R19]
        rom_take && rom_wr.addr == `PTC_ROM_SID_HI
        |=> sid_reg[15:8] == $past(rom_wr.data))
        else $error("subsystem code not loaded");
    chk_rom_svid: assert property ( // [R19]
        rom_take && rom_wr.addr == `PTC_ROM_SVID_LO
        |=> svid_reg[7:0] == $past(rom_wr.data))
        else $error("subsystem vendor code not loaded");
    chk_next_ptr: assert property ( // [R11]
        rd_ack && idx_reg == `PTC_IDX_PM0
        |-> rsp_reg.rdata[15:8] == next0_reg && rsp_reg.rdata[31:16] == 16'h0000)
        else $error("next capability pointer wrong");
    chk_ctrl_read: assert property ( // [R4] [R9]
        take && !cfg_req.write && hit_ctrl
        |=> rsp_reg.rdata[31:6] == base_reg)
        else $error("control base read differs");
    chk_line_read: assert property ( // [R12]
        take && !cfg_req.write && cfg_req.idx == `PTC_IDX_INTR
        |=> rsp_reg.rdata[7:0] == irq_line_reg)
        else $error("interrupt line read differs");
    chk_class_read: assert property ( // [R17] [R18]
        take && !cfg_req.write && cfg_req.idx == `PTC_IDX_CLASS
        |=> rsp_reg.rdata == {class_reg, rev_reg})
        else $error("class or revision read differs");

    cov_ctrl_write: cover property (base_we);
    cov_type1: cover property (cfg_req.valid && !cfg_req.type0 && ready_reg);
    cov_hdr_read: cover property (rd_ack && idx_reg == `PTC_IDX_HDR);
    cov_boot_done: cover property (loading ##1 ready_reg);
    cov_base_readback: cover property (wr_take && hit_ctrl ##3 take && hit_ctrl);

endmodule

// ===== rtl/ptc_defines.svh
// Offsets, reset values and load addresses of the configuration header bank
`ifndef PTC_DEFINES_SVH
`define PTC_DEFINES_SVH

`define PTC_IDX_ID        6'h00
`define PTC_IDX_CMD       6'h01
`define PTC_IDX_CLASS     6'h02
`define PTC_IDX_HDR       6'h03
`define PTC_IDX_BAR0      6'h04
`define PTC_IDX_BAR5      6'h09
`define PTC_IDX_SUBSYS    6'h0b
`define PTC_IDX_CAPPTR    6'h0d
`define PTC_IDX_INTR      6'h0f
`define PTC_IDX_PM0       6'h10

`define PTC_ROM_BAR_SEL   8'h00
`define PTC_ROM_SPACE     8'h01
`define PTC_ROM_REV       8'h08
`define PTC_ROM_CLASS_LO  8'h09
`define PTC_ROM_CLASS_MID 8'h0a
`define PTC_ROM_CLASS_HI  8'h0b
`define PTC_ROM_SVID_LO   8'h2c
`define PTC_ROM_SVID_HI   8'h2d
`define PTC_ROM_SID_LO    8'h2e
`define PTC_ROM_SID_HI    8'h2f
`define PTC_ROM_CAPPTR    8'h34
`define PTC_ROM_NEXT0     8'h41

`define PTC_HDR_TYPE      8'h00
`define PTC_SELF_TEST_CONTROL_VAL      8'h00
`define PTC_CACHE_LINE    8'h00
`define PTC_LAT_TIMER     8'h00
`define PTC_IRQ_PIN       8'h01
`define PTC_MIN_GNT       8'h00
`define PTC_MAX_LAT       8'h00
`define PTC_PM_CAP_ID     8'h01
`define PTC_PM_CAP_OFS    8'h40
`define PTC_IRQ_LINE_RST  8'h00
`define PTC_BAR_UNUSED    32'hffffffff
`define PTC_CTRL_BASE_RST 26'h3ffffff
`define PTC_MEM_TYPE_32   2'b00
`define PTC_ZERO_BYTE     8'h00

`endif

// ===== rtl/ptc_pkg.sv
// Types shared by the configuration header bank
package ptc_pkg;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic        type0;
        logic [5:0]  idx;
        logic [3:0]  be;
        logic [31:0] wdata;
    } ptc_req_t;

    typedef struct packed {
        logic        ack;
        logic [31:0] rdata;
    } ptc_rsp_t;

    typedef struct packed {
        logic       valid;
        logic [7:0] addr;
        logic [7:0] data;
    } ptc_rom_t;

    typedef enum logic [1:0] {
        PTC_LOADING = 2'b00,
        PTC_READY   = 2'b01
    } ptc_state_t;

endpackage

// ===== tb/ptc_config_header_tb.sv
// Self-checking bench for the configuration header bank
`timescale 1ns/1ns
module ptc_config_header_tb;
    import ptc_pkg::*;
    localparam logic [15:0] VC = 16'h1357;  // Arbitrary value
    localparam logic [15:0] DC = 16'h2468;  // Arbitrary value
    logic        clk;
    logic        rst_b;
    ptc_req_t    cfg_req;
    ptc_rom_t    rom_wr;
    logic        rom_done;
    ptc_rsp_t    cfg_rsp;
    logic        cfg_ready;
    logic [25:0] ctrl_base;
    logic        ctrl_is_mem;
    logic        ctrl_in_bar5;
    logic [7:0]  irq_line;
    int          num_errors = 0;
    int          compares = 0;
    int          cycles = 0;
    logic [31:0] seed = 32'h6cef;
    logic [7:0]  m_rev;
    logic [7:0]  m_irq;
    logic [23:0] m_cls;
    logic [31:0] m_sub;
    logic [25:0] m_cb;
    logic        m_mem;
    logic        m_b5;
    logic [31:0] rd;
    logic        ok;

    ptc_config_header #(.VENDOR_CODE(VC), .DEVICE_CODE(DC)) uut (
        .clk(clk), .rst_b(rst_b), .cfg_req(cfg_req), .rom_wr(rom_wr), .rom_done(rom_done),
        .cfg_rsp(cfg_rsp), .cfg_ready(cfg_ready), .ctrl_base(ctrl_base),
        .ctrl_is_mem(ctrl_is_mem), .ctrl_in_bar5(ctrl_in_bar5), .irq_line(irq_line));
    ptc_host_model host (.clk(clk), .cfg_req(cfg_req), .cfg_rsp(cfg_rsp));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // Hang guard, generous against roughly 1350 cycles of real work
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 10000) begin
            num_errors++;
            complete_run();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Expected read word of each dword index
    function automatic logic [31:0] model(input int idx);
        int ci;
        ci = m_b5 ? 9 : 4;
        if (idx == ci) return {m_cb, 5'h0, ~m_mem};
        case (idx)
            0: return {DC, VC};
            2: return {m_cls, m_rev};
            4, 5, 6, 7, 8, 9: return 32'hffffffff;
            11: return m_sub;
            13: return 32'h00000040;
            15: return {24'h000001, m_irq};
            16: return 32'h00000001;
            default: return 32'h0;
        endcase
    endfunction
    ////////////////////////////////////////////////////////////////////////////////
    task automatic rom(input logic [7:0] a, input logic [7:0] d);
        rom_wr = '{valid: 1'b1, addr: a, data: d};
        @(posedge clk);
        #2;
    endtask

    task automatic boot(input logic b5, input logic mem);
        logic [31:0] r;
        int i;
        rst_b = 1'b0;
        repeat (16) @(posedge clk);
        #2;
        rst_b = 1'b1;
        r = rnd();
        {m_cls, m_rev} = r;
        m_sub = rnd();
        m_cb = '1;
        m_irq = 8'h00;
        m_mem = mem;
        m_b5 = b5;
        rom(8'h00, {7'h0, b5});
        rom(8'h01, {7'h0, mem});
        for (i = 0; i < 4; i++) begin
            rom(8'h08 + i[7:0], r[8*i +: 8]);
            rom(8'h2c + i[7:0], m_sub[8*i +: 8]);
        end
        rom(8'h34, 8'h40);
        rom(8'h41, 8'h00);
        rom(8'h3c, 8'h5a);
        rom_wr.valid = 1'b0;
        check({31'h0, cfg_ready}, 32'h0);
        rom_done = 1'b1;
        @(posedge clk);
        #2;
        rom_done = 1'b0;
        for (i = 0; i < 8 && cfg_ready !== 1'b1; i++) @(negedge clk);
        @(posedge clk);
        #2;
        check({31'h0, cfg_ready}, 32'h1);
        check({30'h0, ctrl_in_bar5, ctrl_is_mem}, {30'h0, b5, mem});
        // Late loader bytes must not disturb the loaded revision
        rom(8'h08, ~m_rev);
        rom_wr.valid = 1'b0;
    endtask

    task automatic wr(input logic [5:0] idx, input logic [3:0] be, input logic [31:0] wd);
        logic [31:0] w;
        int k;
        w = {m_cb, 6'h0};
        for (k = 0; k < 4; k++) if (be[k]) w[8*k +: 8] = wd[8*k +: 8];
        if (idx == (m_b5 ? 6'h09 : 6'h04)) m_cb = w[31:6];
        if (idx == 6'h0f && be[0]) m_irq = wd[7:0];
        host.access(1'b1, 1'b1, idx, be, wd, rd, ok);
        check({31'h0, ok}, 32'h1);
        check({6'h0, ctrl_base}, {6'h0, m_cb});
        check({24'h0, irq_line}, {24'h0, m_irq});
    endtask

    task automatic rd_all();
        int i;
        for (i = 0; i < 20; i++) begin
            host.access(1'b0, 1'b1, i[5:0], 4'hf, rnd(), rd, ok);
            check({31'h0, ok}, 32'h1);
            check(rd, model(i));
            check(rd, model(i));
        end
    endtask

    task automatic complete_run();
        $display("compares %0d errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [31:0] r;
        int t;
        int i;
        rst_b = 1'b0;
        rom_done = 1'b0;
        rom_wr = '0;
        // Every base select and space choice, each after a fresh reset
        for (t = 0; t < 4; t++) begin
            @(posedge clk);
            #2;
            boot(t[0], t[1]);
            rd_all();
            for (i = 0; i < 20; i++) wr(i[5:0], 4'hf, 32'hffffffff);
            rd_all();
            for (i = 0; i < 12; i++) begin
                r = rnd();
                wr(r[4] ? 6'h0f : (t[0] ? 6'h09 : 6'h04), r[3:0], rnd());
            end
            // Full write straight followed by a readback of the control base
            wr(t[0] ? 6'h09 : 6'h04, 4'hf, rnd());
            host.access(1'b0, 1'b1, t[0] ? 6'h09 : 6'h04, 4'hf, rnd(), rd, ok);
            check({31'h0, ok}, 32'h1);
            check(rd, model(t[0] ? 9 : 4));
            rd_all();
            host.access(1'b0, 1'b0, 6'h03, 4'hf, 32'h0, rd, ok);
            check({31'h0, ok}, 32'h0);
            $display("test %0d done", t);
        end
        complete_run();
    end
endmodule

// ===== tb/ptc_host_model.sv
// Bus host model issuing configuration cycles to the header bank
`timescale 1ns/1ns
module ptc_host_model (
    input  wire logic              clk,
    output ptc_pkg::ptc_req_t      cfg_req,
    input  wire ptc_pkg::ptc_rsp_t cfg_rsp
);
    import ptc_pkg::*;
    initial cfg_req = '0;
    ////////////////////////////////////////////////////////////////////////////////
    // Request is held until ack is seen high at a rising edge, or for at most 20 edges, then released.
    // Ack and data are read at that edge, before the design updates them.
    // Idle fields flip so that a stale value is never mistaken for a live one.
    task automatic access(input logic wr, input logic t0, input logic [5:0] idx,
                          input logic [3:0] be, input logic [31:0] wd,
                          output logic [31:0] rd, output logic ok);
        int n;
        ok = 1'b0;
        rd = 32'h0;
        @(posedge clk);
        #2;
        cfg_req = '{valid: 1'b1, write: wr, type0: t0, idx: idx, be: be, wdata: wd};
        for (n = 0; n < 20 && !ok; n++) begin
            @(posedge clk);
            ok = (cfg_rsp.ack === 1'b1);
            if (ok) rd = cfg_rsp.rdata;
        end
        #2;
        cfg_req = '{valid: 1'b0, write: ~wr, type0: ~t0, idx: ~idx, be: ~be, wdata: ~wd};
    endtask
endmodule
